// ===== common/sleep_seq_consts.vh
`ifndef SLEEP_SEQ_CONSTS_VH
`define SLEEP_SEQ_CONSTS_VH
// Clock rate and time units
`define CLK_MHZ 200
`define SLEEP_UNIT_US 10000
`define WAKE_UNIT_US 1000
`define SLEEP_UNIT_CYC (`SLEEP_UNIT_US * `CLK_MHZ)
`define WAKE_UNIT_CYC (`WAKE_UNIT_US * `CLK_MHZ)
// Sleep mode selector codes
`define MODE_CYCLIC 3'h4
`define MODE_CYCLIC_PIN 3'h5
// Sleep option bits
`define OPT_EXT_BIT 2
`define OPT_WAKE_TIME_BIT 1
// Sample interval meaning one sample only
`define ONE_SHOT_IVAL 16'h0800
// Pin config values
`define PIN_DISABLED 3'h0
`define PIN_DIN_MON 3'h3
`define PIN_MAX 3'h6
// Parent timeouts in 10 ms units
`define BUF_MIN_U 32'h00000078
`define BUF_MAX_U 32'h00000bb8
`define POLL_MIN_U 32'h000001f4
`define POLL_MULT 32'h00000003
// Short sleep limit in 10 ms units
`define SHORT_SLEEP_U 32'h00000bb8
`endif

// ===== src/unit_tick.v
`timescale 1ns/100ps
// Free-running divider: one pulse every DIV cycles
module unit_tick #(
  parameter DIV = 2000000
) (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_clear,
  output reg o_tick
);
  reg [31:0] cnt_q; // Cycle count within the unit

  // Count cycles, pulse at wrap, restart on clear
  always @(posedge i_mclk) begin
    if (!i_rst_b || i_clear) begin
      cnt_q <= 32'h0;
      o_tick <= 1'b0;
    end else if (cnt_q == DIV - 1) begin
      cnt_q <= 32'h0;
      o_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      o_tick <= 1'b0;
    end
  end
endmodule

// ===== src/sleep_wake_seq.v
`timescale 1ns/100ps
`include "sleep_seq_consts.vh"
// Function
// - Sleep period counted in 10 ms units
// - Awake time and interval in 1 ms units
// - Mode 4 cyclic, 5 cyclic plus pin wake
// - Indicator asserts once per cycle group
// - Sample every interval until awake timer ends
// - Extended sleep lasts period times cycle count
// - Option 0x06 stays awake full awake time unless a sleep-immediately command ends it
// - Interval 0x800 sends exactly one sample
// - Sleep-immediately command forces sleep at once
// - Parent drops child after three missed cycle groups
// - Short sleepers can receive data anytime
// - Pin value 3 makes monitored digital input
// - Buffer time 1.2 x period, clamped 1.2-30 s
// - Poll timeout triple period times count, 5 s min
module sleep_wake_seq #(
  parameter SLEEP_DIV = `SLEEP_UNIT_CYC,
  parameter WAKE_DIV = `WAKE_UNIT_CYC
) (
  input wire i_mclk,
  input wire i_rst_b,
  input wire [2:0] i_sleep_mode_select,
  input wire [15:0] i_sleep_period,
  input wire [7:0] i_sleep_cycle_count,
  input wire [2:0] i_sleep_options,
  input wire [15:0] i_awake_time,
  input wire [15:0] i_sample_interval,
  input wire i_line1_cfg_wr,
  input wire [3:0] i_line1_cfg_val,
  input wire i_analog_enabled,
  input wire i_sleep_now,
  input wire i_sleep_rq,
  input wire i_rx_data,
  output reg [2:0] o_line1_pin_config,
  output wire o_line1_monitored,
  output reg o_awake,
  output reg o_on_sleep,
  output reg o_sample,
  output reg o_can_rx_any,
  output reg [31:0] o_buffer_timeout,
  output reg [31:0] o_poll_timeout
);
  // State codes of the sequencer
  localparam STATE_SLEEP = 2'h0; // Counting a sleep period
  localparam STATE_WAKE = 2'h1; // Awake window
  localparam STATE_IDLE = 2'h2; // Mode not cyclic

  // Sequencer state and its unit counters
  reg [1:0] state_q; // Current sequencer state
  reg [15:0] per_cnt_q; // 10 ms units elapsed in period
  reg [7:0] cyc_cnt_q; // Sleep periods elapsed in group
  reg [15:0] wake_cnt_q; // 1 ms units elapsed awake
  reg [15:0] samp_cnt_q; // 1 ms units since last sample

  // Unit pulses from the two time bases
  wire sleep_tick; // One 10 ms unit has passed
  wire wake_tick; // One 1 ms unit has passed
  // Decoded settings
  wire cyclic; // Mode 4 or 5 selected
  wire pin_wake; // Mode 5 with the request pin high
  wire wake_early; // Radio data or pin ends sleep early
  wire ext_sleep; // Extended sleep option set
  wire samp_en; // Sampling has an interval and a line
  wire one_shot; // Interval asks for a single sample
  wire [7:0] cyc_eff; // Cycle count with zero taken as one
  // Counter end points
  wire group_end; // Last period of the group
  wire period_end; // Last unit of the period
  wire wake_end; // Last unit of the awake window
  wire samp_due; // Sample interval elapsed
  // Parent timeout terms before clamping
  wire [31:0] buf_raw; // 1.2 times the sleep period
  wire [31:0] poll_raw; // Three periods times cycle count

  // Range check of a line-1 pin value
  // Values 0 and 2 to 6 are legal on this line
  function val_ok;
    input [3:0] v;
    begin
      val_ok = (v == 4'h0) || ((v >= 4'h2) && (v <= {1'b0, `PIN_MAX}));
    end
  endfunction

  // Clamp a value between two bounds
  // Both bounds are inclusive
  function [31:0] clamp;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      if (v < lo)
        clamp = lo;
      else if (v > hi)
        clamp = hi;
      else
        clamp = v;
    end
  endfunction

  // Treat a zero cycle count as a single period
  function [7:0] eff_count;
    input [7:0] n;
    begin
      if (n == 8'h0)
        eff_count = 8'h1;
      else
        eff_count = n;
    end
  endfunction

  // Next count reaches or passes its limit; wide to avoid wrap
  function reached;
    input [15:0] cnt;
    input [15:0] lim;
    begin
      reached = (({1'b0, cnt} + 17'h00001) >= {1'b0, lim});
    end
  endfunction

  // Sleep time base, held at zero outside a sleep period
  unit_tick #(.DIV(SLEEP_DIV)) u_sleep_tick (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_clear(state_q != STATE_SLEEP),
    .o_tick(sleep_tick)
  );
  // Wake time base, so the first unit starts at wake entry
  unit_tick #(.DIV(WAKE_DIV)) u_wake_tick (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_clear(state_q != STATE_WAKE),
    .o_tick(wake_tick)
  );

  // Mode and option decode
  assign cyclic = (i_sleep_mode_select == `MODE_CYCLIC) ||
                  (i_sleep_mode_select == `MODE_CYCLIC_PIN);
  // Only mode 5 lets the request pin end a sleep
  assign pin_wake = i_sleep_rq &&
                    (i_sleep_mode_select == `MODE_CYCLIC_PIN);
  // Early wake by radio data or the pin
  assign wake_early = i_rx_data || pin_wake;
  assign ext_sleep = i_sleep_options[`OPT_EXT_BIT];
  assign cyc_eff = eff_count(i_sleep_cycle_count);
  // Sampling needs an interval and an enabled line
  assign samp_en = (i_sample_interval != 16'h0) &&
                   (o_line1_monitored || i_analog_enabled);
  assign one_shot = (i_sample_interval == `ONE_SHOT_IVAL);
  // Period and wake end points fire only on the unit pulse of their time base
  assign period_end = sleep_tick &&
                      reached(per_cnt_q, i_sleep_period);
  assign group_end = reached({8'h00, cyc_cnt_q}, {8'h00, cyc_eff});
  assign wake_end = wake_tick &&
                    reached(wake_cnt_q, i_awake_time);
  assign samp_due = samp_en && !one_shot &&
                    reached(samp_cnt_q, i_sample_interval);
  // A line set to value 3 is watched by sampling
  assign o_line1_monitored = (o_line1_pin_config == `PIN_DIN_MON);
  // Parent timeout terms in 10 ms units
  assign buf_raw = ({16'h0000, i_sleep_period} * 32'h0000000c) /
                   32'h0000000a;
  assign poll_raw = `POLL_MULT * {16'h0000, i_sleep_period} *
                    {24'h000000, cyc_eff};

  // Line-1 pin configuration register
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      // Line starts disabled
      o_line1_pin_config <= `PIN_DISABLED;
    end else if (i_line1_cfg_wr && val_ok(i_line1_cfg_val)) begin
      // Legal value replaces the setting
      o_line1_pin_config <= i_line1_cfg_val[2:0];
    end
    // Refused values leave the old setting in place
  end

  // Sleep and wake state machine
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      // Idle and awake until a cyclic mode is chosen
      state_q <= STATE_IDLE;
      per_cnt_q <= 16'h0;
      cyc_cnt_q <= 8'h0;
      wake_cnt_q <= 16'h0;
      samp_cnt_q <= 16'h0;
      o_awake <= 1'b1;
      o_on_sleep <= 1'b1;
      o_sample <= 1'b0;
    end else begin
      // Sample strobe is a single-cycle pulse by default
      o_sample <= 1'b0;
      case (state_q)
        STATE_IDLE: begin
          // Non-cyclic modes stay awake
          o_awake <= 1'b1;
          o_on_sleep <= 1'b1;
          if (cyclic) begin
            // Start the first group from zero
            state_q <= STATE_SLEEP;
            per_cnt_q <= 16'h0;
            cyc_cnt_q <= 8'h0;
            o_awake <= 1'b0;
            o_on_sleep <= 1'b0;
          end
        end
        STATE_SLEEP: begin
          if (!cyclic) begin
            // Leaving cyclic sleep wakes at once
            state_q <= STATE_IDLE;
            o_awake <= 1'b1;
            o_on_sleep <= 1'b1;
          end else if (wake_early) begin
            // Early wake asserts the indicator and restarts the group
            state_q <= STATE_WAKE;
            o_awake <= 1'b1;
            o_on_sleep <= 1'b1;
            cyc_cnt_q <= 8'h0;
            wake_cnt_q <= 16'h0;
            samp_cnt_q <= 16'h0;
            // First sample goes out on waking
            o_sample <= samp_en;
          end else if (period_end) begin
            // Period over: restart its unit count
            per_cnt_q <= 16'h0;
            if (group_end) begin
              // Wake with indicator once per group
              state_q <= STATE_WAKE;
              cyc_cnt_q <= 8'h0;
              o_awake <= 1'b1;
              o_on_sleep <= 1'b1;
              wake_cnt_q <= 16'h0;
              samp_cnt_q <= 16'h0;
              // One sample on waking, also in one-shot mode
              o_sample <= samp_en;
            end else if (!ext_sleep) begin
              // Brief poll wake without the indicator
              cyc_cnt_q <= cyc_cnt_q + 8'h1;
              o_awake <= 1'b1;
            end else begin
              // Extended sleep keeps sleeping through group
              cyc_cnt_q <= cyc_cnt_q + 8'h1;
              o_awake <= 1'b0;
            end
          end else if (sleep_tick) begin
            // One more 10 ms unit of the period
            per_cnt_q <= per_cnt_q + 16'h1;
            o_awake <= 1'b0;
          end else begin
            // Between units; a poll wake lasts one cycle
            o_awake <= 1'b0;
          end
        end
        STATE_WAKE: begin
          if (i_sleep_now || wake_end || !cyclic) begin
            // Command or timer ends the awake window
            state_q <= cyclic ? STATE_SLEEP : STATE_IDLE;
            per_cnt_q <= 16'h0;
            // A non-cyclic mode stays awake in idle
            o_awake <= !cyclic;
            o_on_sleep <= !cyclic;
          end else if (wake_tick) begin
            // One more 1 ms unit of the window
            wake_cnt_q <= wake_cnt_q + 16'h1;
            if (samp_due) begin
              // Interval elapsed: pulse and restart it
              samp_cnt_q <= 16'h0;
              o_sample <= 1'b1;
            end else begin
              // Interval still running
              samp_cnt_q <= samp_cnt_q + 16'h1;
            end
          end
        end
        default: begin
          // Unused code returns to idle
          state_q <= STATE_IDLE;
        end
      endcase
    end
  end

  // Parent timeouts and short-sleep flag, 10 ms units
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      // Floors of both timeouts until settings are seen
      o_buffer_timeout <= `BUF_MIN_U;
      o_poll_timeout <= `POLL_MIN_U;
      o_can_rx_any <= 1'b0;
    end else begin
      // Buffer time is clamped both ways
      o_buffer_timeout <= clamp(buf_raw, `BUF_MIN_U, `BUF_MAX_U);
      // Poll timeout has only a floor; it outlasts three periods
      o_poll_timeout <= clamp(poll_raw, `POLL_MIN_U,
                              32'hffffffff);
      // Extended sleepers may outlast the parent's buffer
      o_can_rx_any <= ({16'h0000, i_sleep_period} < `SHORT_SLEEP_U) &&
                      !ext_sleep;
    end
  end
endmodule

// ===== dv/sleep_wake_seq_chk.sv
`timescale 1ns/100ps
// Port checker for the sleep sequencer
module sleep_wake_seq_chk (
  input wire i_mclk,
  input wire i_rst_b,
  input wire [2:0] i_sleep_mode_select,
  input wire [15:0] i_sleep_period,
  input wire [7:0] i_sleep_cycle_count,
  input wire [2:0] i_sleep_options,
  input wire [15:0] i_sample_interval,
  input wire i_line1_cfg_wr,
  input wire [3:0] i_line1_cfg_val,
  input wire i_sleep_now,
  input wire [2:0] o_line1_pin_config,
  input wire o_line1_monitored,
  input wire o_awake,
  input wire o_sample,
  input wire o_can_rx_any,
  input wire [31:0] o_poll_timeout
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // Legal pin value, poll floor, short sleep and cyclic mode
  wire ok_val = i_line1_cfg_val != 4'h1 && i_line1_cfg_val < 4'h7;
  wire [7:0] n1 = (i_sleep_cycle_count == 8'h0) ? 8'h1 : i_sleep_cycle_count;
  wire [31:0] raw = 32'h3 * i_sleep_period * n1;
  wire [31:0] poll = (raw < 32'h1f4) ? 32'h1f4 : raw;
  wire short_ok = i_sleep_period < 16'hbb8 && !i_sleep_options[2];
  wire cyc_m = i_sleep_mode_select == 3'h4 || i_sleep_mode_select == 3'h5;
  property p_take; i_line1_cfg_wr && ok_val |=>
    {1'b0, o_line1_pin_config} == $past(i_line1_cfg_val); endproperty
  a_take: assert property (p_take) else $error("cfg not taken");
  property p_keep; i_line1_cfg_wr && !ok_val |=>
    $stable(o_line1_pin_config); endproperty
  a_keep: assert property (p_keep) else $error("bad cfg taken");
  property p_mon; o_line1_monitored == (o_line1_pin_config == 3'h3);
  endproperty
  a_mon: assert property (p_mon) else $error("monitor flag wrong");
  property p_now; i_sleep_now && o_awake && cyc_m |=> !o_awake; endproperty
  a_now: assert property (p_now) else $error("no forced sleep");
  property p_off; $past(i_sample_interval) == 16'h0 |-> !o_sample;
  endproperty
  a_off: assert property (p_off) else $error("sample while off");
  property p_poll; $past(i_rst_b) |-> o_poll_timeout == $past(poll);
  endproperty
  a_poll: assert property (p_poll) else $error("poll timeout wrong");
  property p_rx; $past(i_rst_b) |-> o_can_rx_any == $past(short_ok);
  endproperty
  a_rx: assert property (p_rx) else $error("short flag wrong");
  property p_pulse; o_sample |=> !o_sample; endproperty
  a_pulse: assert property (p_pulse) else $error("sample too long");
endmodule

// ===== dv/host_model.sv
`timescale 1ns/100ps
// Host: pin config or sleep command as a one-cycle strobe
module host_model (
  input wire i_mclk,
  output reg o_cfg_wr = 1'b0,
  output reg [3:0] o_cfg_val = 4'h0,
  output reg o_sleep_now = 1'b0
);
  // Parameter travels as a binary value beside its strobe
  task send(input c, input [3:0] v);
    begin
      @(posedge i_mclk);
      o_cfg_wr <= c;
      o_cfg_val <= v;
      o_sleep_now <= !c;
      @(posedge i_mclk);
      o_cfg_wr <= 1'b0;
      o_sleep_now <= 1'b0;
      o_cfg_val <= ~v; // Stale value is not held
    end
  endtask
endmodule

// ===== dv/testbench.sv
`timescale 1ns/100ps
// Bench for the sleep and wake sequencer
module testbench;
  reg i_mclk = 1'b0, i_rst_b = 1'b0, i_sleep_rq = 1'b0, i_rx_data = 1'b0;
  reg [2:0] i_sleep_mode_select = 3'h0, i_sleep_options = 3'h0;
  reg [15:0] i_sleep_period = 16'h2, i_awake_time = 16'h4;
  reg [15:0] i_sample_interval = 16'h0;
  reg [7:0] i_sleep_cycle_count = 8'h3;
  reg i_analog_enabled = 1'b1;
  wire i_line1_cfg_wr, i_sleep_now, o_line1_monitored, o_awake, o_on_sleep;
  wire o_sample, o_can_rx_any;
  wire [3:0] i_line1_cfg_val;
  wire [2:0] o_line1_pin_config;
  wire [31:0] o_buffer_timeout, o_poll_timeout;
  integer fail_count = 0, checks_done = 0, cyc = 0, k, n;
  initial forever #2.5 i_mclk = ~i_mclk;
  host_model host_model_i (.i_mclk(i_mclk), .o_cfg_wr(i_line1_cfg_wr),
    .o_cfg_val(i_line1_cfg_val), .o_sleep_now(i_sleep_now));
  sleep_wake_seq #(.SLEEP_DIV(4), .WAKE_DIV(2)) sleep_wake_seq_i (.*);
  // Range compare; equal bounds give an exact compare
  task check(input string s, input [31:0] lo, hi, got);
    begin
      checks_done = checks_done + 1;
      if (^got === 1'bx || got < lo || got > hi) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %s expected %0d got %0d", s, lo, got);
      end
    end
  endtask
  task tick;
    begin
      @(posedge i_mclk);
      #1;
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Pin values 8 down to 0; refused values keep the old setting
  task t_cfg;
    reg [2:0] e;
    begin
      e = 3'h0;
      for (k = 8; k >= 0; k = k - 1) begin
        host_model_i.send(1'b1, k[3:0]);
        #1;
        if (k != 1 && k < 7) e = k[2:0];
        check("pin config", e, e, o_line1_pin_config);
        check("monitored", e == 3, e == 3, o_line1_monitored);
      end
    end
  endtask
  // Parent timeouts from period and count, non-cyclic mode
  task t_time(input [15:0] p, input [7:0] c, input [2:0] o);
    reg [31:0] e;
    begin
      @(posedge i_mclk);
      i_sleep_period <= p;
      i_sleep_cycle_count <= c;
      i_sleep_options <= o;
      repeat (2) tick;
      e = 3 * p * c;
      e = e < 500 ? 500 : e;
      check("poll", e, e, o_poll_timeout);
      e = p * 12 / 10;
      e = e < 120 ? 120 : (e > 3000 ? 3000 : e);
      check("buffer", e, e, o_buffer_timeout);
      e = p < 3000 && !o[2];
      check("rx any", e, e, o_can_rx_any);
      check("stay awake", 1, 1, o_awake);
    end
  endtask
  // One sleep group, then the awake window and its samples
  task t_cyc(input [2:0] m, o, input [15:0] r, input [31:0] lo, hi);
    begin
      @(posedge i_mclk);
      i_sleep_mode_select <= 3'h0;
      i_sleep_period <= 16'h2;
      i_sleep_cycle_count <= 8'h3;
      i_sleep_options <= o;
      i_sample_interval <= r;
      repeat (3) @(posedge i_mclk);
      i_sleep_mode_select <= m;
      for (k = 0; o_on_sleep !== 1'b0 && k < 20; k = k + 1) tick;
      n = 0;
      for (k = 0; o_on_sleep !== 1'b1 && k < 60; k = k + 1) begin
        tick;
        n = n + o_awake;
      end
      check("sleep length", 20, 28, k);
      check("short wakes", o[2] ? 1 : 3, o[2] ? 1 : 3, n);
      n = 0;
      for (k = 0; o_awake === 1'b1 && k < 40; k = k + 1) begin
        n = n + o_sample;
        tick;
      end
      check("awake window", 6, 10, k);
      check("samples", lo, hi, n);
    end
  endtask
  // Forced sleep mid window, then radio data raises the indicator
  task t_now;
    begin
      @(posedge i_mclk);
      i_awake_time <= 16'h40;
      for (k = 0; o_on_sleep !== 1'b1 && k < 60; k = k + 1) tick;
      host_model_i.send(1'b0, 4'h0);
      #1;
      check("forced sleep", 0, 0, o_awake);
      @(posedge i_mclk);
      i_rx_data <= 1'b1;
      @(posedge i_mclk);
      i_rx_data <= 1'b0;
      tick;
      check("data wake", 1, 1, o_on_sleep);
    end
  endtask
  // Request pin is ignored in mode 4 and wakes in mode 5
  task t_pin;
    begin
      host_model_i.send(1'b0, 4'h0);
      @(posedge i_mclk);
      i_sleep_rq <= 1'b1;
      repeat (3) tick;
      check("pin ignored", 0, 0, o_on_sleep);
      @(posedge i_mclk);
      i_sleep_mode_select <= 3'h5;
      repeat (2) tick;
      check("pin wake", 1, 1, o_on_sleep);
      @(posedge i_mclk);
      i_sleep_rq <= 1'b0;
    end
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_cfg;
    t_time(16'h32, 8'h1, 3'h0);
    t_time(16'h7d0, 8'h3, 3'h0);
    t_time(16'hbb8, 8'hc, 3'h4);
    @(posedge i_mclk);
    i_analog_enabled <= 1'b0;
    t_cyc(3'h4, 3'h0, 16'h1, 0, 0);
    host_model_i.send(1'b1, 4'h3);
    t_cyc(3'h5, 3'h0, 16'h1, 3, 5);
    t_cyc(3'h4, 3'h6, 16'h800, 1, 1);
    t_now;
    t_pin;
    stop_test;
  end
  // Cycle ceiling for a hung run
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
endmodule
bind sleep_wake_seq sleep_wake_seq_chk sleep_wake_seq_chk_i (.*);
